// file: core/vcmd_cfg.svh
// offsets, reset values and timing counts of the velocity command selector
`ifndef VCMD_CFG_SVH
`define VCMD_CFG_SVH
// =====================================================================
// register byte offsets
`define VC_OFF_CTRL     8'h00
`define VC_OFF_PRESET1  8'h04
`define VC_OFF_PRESET2  8'h08
`define VC_OFF_PRESET3  8'h0C
`define VC_OFF_FSCALE   8'h10
`define VC_OFF_OFFSET   8'h14
`define VC_OFF_ACCEL    8'h18
`define VC_OFF_DECEL    8'h1C
`define VC_OFF_SCURVE   8'h20
`define VC_OFF_CMDFILT  8'h24
`define VC_OFF_RESLP    8'h28
`define VC_OFF_NFREQ    8'h2C
`define VC_OFF_NDEPTH   8'h30
`define VC_OFF_STATUS   8'h34
`define VC_OFF_CMDOUT   8'h38
// =====================================================================
// control field positions
`define VC_CTRL_ZERO    0
`define VC_CTRL_TORQUE  1
// =====================================================================
// reset values
`define VC_RST_FSCALE   16'h0BB8
`define VC_RST_RAMP     16'h00C8
`define VC_RST_NFREQ    16'h03E8
// =====================================================================
// limits and scaling
`define VC_AIN_MAX_MV   16'h2710
`define VC_PRESET_LIM   16'h1388
`define VC_NFREQ_MIN    16'h0032
`define VC_NFREQ_MAX    16'h03E8
`define VC_NDEPTH_MAX   8'h20
`define VC_RAMP_NUM     32'h0001_2C00
`define VC_NOTCH_FQ     16'h0029
// =====================================================================
// timing: one control sample period
`define VC_CLK_HZ       50000000
`define VC_SAMPLE_NS    100000
`define VC_SAMPLE_CYC   (`VC_SAMPLE_NS / (1000000000 / `VC_CLK_HZ))
`endif

// file: core/vcmd_pkg.sv
// types shared by the velocity command selector
package vcmd_pkg;
    typedef enum logic [2:0] {SRC_ANALOG, SRC_ZERO, SRC_PRESET1, SRC_PRESET2,
                              SRC_PRESET3} cmd_src_t;
    typedef logic signed [15:0] rpm_t;
endpackage

// file: core/stage_if.sv
// one sample stage of the command filter chain
`timescale 1ns/1ps
interface stage_if;
    logic              valid;
    logic signed [15:0] data;
    modport src (output valid, output data);
    modport dst (input valid, input data);
endinterface

// file: core/iir_lowpass.sv
// first-order low-pass, cutoff inverse to setting, bypass at zero
`timescale 1ns/1ps
module iir_lowpass (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // divisor setting
    input  wire logic [7:0] setting,
    // stages
    stage_if.dst            in_s,
    stage_if.src            out_s
);
    logic signed [23:0] acc_r;
    logic               vld_r;
    // sign kept: an unsigned concat would zero-extend negative commands
    wire  signed [24:0] diff = 25'($signed({in_s.data, 8'h00})) - 25'(acc_r);
    // alpha = 1/setting, so cutoff falls as setting grows
    wire  signed [24:0] step = diff / $signed({1'b0, setting});
    wire                pass = (setting <= 8'h01);

    // one update per sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= '0;
            vld_r <= 1'b0;
        end else begin
            vld_r <= in_s.valid;
            if (in_s.valid) begin
                acc_r <= pass ? {in_s.data, 8'h00} : acc_r + step[23:0];
            end
        end
    end
    assign out_s.valid = vld_r;
    assign out_s.data  = acc_r[23:8];
endmodule

// file: core/s_curve_shaper.sv
// ramp limiter with accel/decel rates plus s-curve rounding
`timescale 1ns/1ps
`include "vcmd_cfg.svh"
module s_curve_shaper (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // time constants in ms for 0 to 3000 rpm
    input  wire logic [15:0] accel_ms,
    input  wire logic [15:0] decel_ms,
    input  wire logic [7:0]  s_const,
    // stages
    stage_if.dst             in_s,
    stage_if.src             out_s
);
    logic signed [23:0] ramp_r;
    logic signed [23:0] smooth_r;
    logic               vld_r;
    wire  signed [23:0] tgt = {in_s.data, 8'h00};
    // away from zero is acceleration, toward zero deceleration
    wire         accel = (tgt > ramp_r && ramp_r >= 0) || (tgt < ramp_r && ramp_r <= 0);
    wire  [15:0] t_ms  = accel ? accel_ms : decel_ms;
    wire  [31:0] rate  = (t_ms == 16'h0000) ? 32'h00FF_FFFF : `VC_RAMP_NUM / {16'h0000, t_ms};
    wire  signed [24:0] gap  = 25'(tgt) - 25'(ramp_r);
    wire  [24:0]        agap = gap[24] ? 25'(-gap) : gap;
    wire  signed [23:0] ramp_nxt = (agap <= 25'(rate)) ? tgt :
                                   gap[24] ? ramp_r - 24'(rate) : ramp_r + 24'(rate);
    // rounding stage softens the corners of the linear ramp
    wire  signed [24:0] sdiff  = 25'(ramp_nxt) - 25'(smooth_r);
    wire  signed [24:0] sstep  = sdiff / $signed({1'b0, s_const});
    wire  signed [23:0] smooth_nxt = (s_const <= 8'h01) ? ramp_nxt : smooth_r + sstep[23:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ramp_r   <= '0;
            smooth_r <= '0;
            vld_r    <= 1'b0;
        end else begin
            vld_r <= in_s.valid;
            if (in_s.valid) begin
                ramp_r   <= ramp_nxt;
                smooth_r <= smooth_nxt;
            end
        end
    end
    assign out_s.valid = vld_r;
    assign out_s.data  = smooth_r[23:8];
endmodule

// file: core/velocity_command_select.sv
// velocity command source select, scaling, shaping and resonance filters
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "vcmd_cfg.svh"
// Operation
// - analog mode, select 00: analog +-10 V
// - zero mode, select 00: command zero
// - select 01/10/11 picks preset, +-5000 rpm
// - select change applies at once
// - source from selects plus mode setting
// - torque mode: commands act as limits
// - scale full_scale/10 times volts minus offset
// - s-curve from accel, decel, smoothing
// - command filter on preset and analog
// - command filter bypassed at setting zero
// - resonance low-pass cutoff inverse to setting
// - notch 50-1000 Hz, 0-32 dB depth
module velocity_command_select #(
    parameter int SAMPLE_CYCLES = `VC_SAMPLE_CYC
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // controller inputs
    input  wire logic          speed_select_bit0,
    input  wire logic          speed_select_bit1,
    input  wire logic signed [15:0] analog_ref_mv,
    // speed loop side
    output vcmd_pkg::rpm_t     speed_cmd,
    output vcmd_pkg::rpm_t     speed_limit,
    output logic               cmd_valid
);
    import vcmd_pkg::*;

    // =================================================================
    // elaboration check
    if (SAMPLE_CYCLES < 16) begin : g_bad
        $error("SAMPLE_CYCLES too small for the filter chain");
    end

    // =================================================================
    // helpers
    function automatic logic signed [15:0] clamp(input logic signed [33:0] v,
                                                 input logic [15:0] lim);
        if (v > $signed({18'h0_0000, lim}))
            clamp = $signed(lim);
        else if (v < -$signed({18'h0_0000, lim}))
            clamp = -$signed(lim);
        else
            clamp = v[15:0];
    endfunction

    function automatic logic [15:0] clamp_u(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp_u = (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    // =================================================================
    // registers
    logic [1:0]  ctrl_r;
    rpm_t        preset_r [3];
    logic [15:0] fscale_r;
    logic signed [15:0] offset_r;
    logic [15:0] accel_r;
    logic [15:0] decel_r;
    logic [7:0]  scurve_r;
    logic [7:0]  cmdfilt_r;
    logic [7:0]  reslp_r;
    logic [15:0] nfreq_r;
    logic [7:0]  ndepth_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] hrdata_r;

    // address phase decode
    wire       addr_ph = hsel && hready && htrans[1];
    wire [7:0] a       = haddr[7:0];
    wire       in_map  = (haddr[31:8] == 24'h00_0000) && (a[1:0] == 2'b00);
    wire       wsel    = wr_pend_r;
    wire       mode_zero   = ctrl_r[`VC_CTRL_ZERO];
    wire       mode_torque = ctrl_r[`VC_CTRL_TORQUE];

    // =================================================================
    // selection state used by status reads
    logic [1:0] sel_r;
    cmd_src_t   src_r;
    rpm_t       raw_r;
    logic       raw_vld_r;
    rpm_t       speed_cmd_r;
    rpm_t       speed_limit_r;
    logic       cmd_valid_r;

    // read mux, unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_map) begin
            unique case (a)
                `VC_OFF_CTRL:    rd_mux = {30'h0, ctrl_r};
                `VC_OFF_PRESET1: rd_mux = 32'(preset_r[0]);
                `VC_OFF_PRESET2: rd_mux = 32'(preset_r[1]);
                `VC_OFF_PRESET3: rd_mux = 32'(preset_r[2]);
                `VC_OFF_FSCALE:  rd_mux = {16'h0000, fscale_r};
                `VC_OFF_OFFSET:  rd_mux = 32'(offset_r);
                `VC_OFF_ACCEL:   rd_mux = {16'h0000, accel_r};
                `VC_OFF_DECEL:   rd_mux = {16'h0000, decel_r};
                `VC_OFF_SCURVE:  rd_mux = {24'h00_0000, scurve_r};
                `VC_OFF_CMDFILT: rd_mux = {24'h00_0000, cmdfilt_r};
                `VC_OFF_RESLP:   rd_mux = {24'h00_0000, reslp_r};
                `VC_OFF_NFREQ:   rd_mux = {16'h0000, nfreq_r};
                `VC_OFF_NDEPTH:  rd_mux = {24'h00_0000, ndepth_r};
                `VC_OFF_STATUS:  rd_mux = {27'h000_0000, src_r, sel_r};
                `VC_OFF_CMDOUT:  rd_mux = {speed_limit_r, speed_cmd_r};
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // bus handshake, zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ph && hwrite && in_map;
            if (addr_ph) begin
                wr_addr_r <= a;
            end
            if (addr_ph && !hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // register writes in the data phase; presets and notch clamped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r    <= 2'b00;
            preset_r  <= '{default: 16'h0000};
            fscale_r  <= `VC_RST_FSCALE;
            offset_r  <= 16'h0000;
            accel_r   <= `VC_RST_RAMP;
            decel_r   <= `VC_RST_RAMP;
            scurve_r  <= 8'h00;
            cmdfilt_r <= 8'h00;
            reslp_r   <= 8'h00;
            nfreq_r   <= `VC_RST_NFREQ;
            ndepth_r  <= 8'h00;
        end else if (wsel) begin
            unique case (wr_addr_r)
                `VC_OFF_CTRL:    ctrl_r    <= hwdata[1:0];
                `VC_OFF_PRESET1: preset_r[0] <= clamp(34'($signed(hwdata)), `VC_PRESET_LIM);
                `VC_OFF_PRESET2: preset_r[1] <= clamp(34'($signed(hwdata)), `VC_PRESET_LIM);
                `VC_OFF_PRESET3: preset_r[2] <= clamp(34'($signed(hwdata)), `VC_PRESET_LIM);
                `VC_OFF_FSCALE:  fscale_r  <= hwdata[15:0];
                `VC_OFF_OFFSET:  offset_r  <= hwdata[15:0];
                `VC_OFF_ACCEL:   accel_r   <= hwdata[15:0];
                `VC_OFF_DECEL:   decel_r   <= hwdata[15:0];
                `VC_OFF_SCURVE:  scurve_r  <= hwdata[7:0];
                `VC_OFF_CMDFILT: cmdfilt_r <= hwdata[7:0];
                `VC_OFF_RESLP:   reslp_r   <= hwdata[7:0];
                `VC_OFF_NFREQ:   nfreq_r <= clamp_u(hwdata[15:0], `VC_NFREQ_MIN, `VC_NFREQ_MAX);
                `VC_OFF_NDEPTH:  ndepth_r <= (hwdata[7:0] > `VC_NDEPTH_MAX) ?
                                             `VC_NDEPTH_MAX : hwdata[7:0];
                default: ;
            endcase
        end
    end

    // =================================================================
    // sample timer; a select change also starts a sample
    logic [$clog2(SAMPLE_CYCLES)-1:0] tmr_r;
    wire [1:0] sel_now  = {speed_select_bit1, speed_select_bit0};
    wire       sel_chg  = (sel_now != sel_r);
    wire       tmr_end  = (tmr_r == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1));
    wire       tick     = tmr_end || sel_chg;

    wire signed [15:0] ain = clamp(34'(analog_ref_mv), `VC_AIN_MAX_MV);
    // full_scale/10 * (mv - offset)/1000 = full_scale*(mv-offset)/10000
    wire signed [33:0] aprod = $signed({18'h0_0000, fscale_r}) * (34'(ain) - 34'(offset_r));
    wire rpm_t         acmd  = clamp(aprod / 34'sd10000, fscale_r);

    // source decode from selects and mode
    wire cmd_src_t src_nxt = (sel_now == 2'b01) ? SRC_PRESET1 :
                             (sel_now == 2'b10) ? SRC_PRESET2 :
                             (sel_now == 2'b11) ? SRC_PRESET3 :
                             mode_zero ? SRC_ZERO : SRC_ANALOG;
    logic signed [15:0] raw_nxt;
    always_comb begin
        raw_nxt = 16'h0000;
        unique case (src_nxt)
            SRC_ANALOG:  raw_nxt = acmd;        // analog source
            SRC_ZERO:    raw_nxt = 16'h0000;    // analog ignored
            SRC_PRESET1: raw_nxt = preset_r[0]; // presets
            SRC_PRESET2: raw_nxt = preset_r[1];
            SRC_PRESET3: raw_nxt = preset_r[2];
        endcase
    end

    // sample start registers the selected command
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_r     <= '0;
            sel_r     <= 2'b00;
            src_r     <= SRC_ANALOG;
            raw_r     <= 16'h0000;
            raw_vld_r <= 1'b0;
        end else begin
            tmr_r     <= tick ? '0 : tmr_r + 1'b1;
            sel_r     <= sel_now;
            raw_vld_r <= tick;
            if (tick) begin
                src_r <= src_nxt;
                raw_r <= raw_nxt;
            end
        end
    end

    // =================================================================
    // filter chain
    stage_if raw_s ();
    stage_if shp_s ();
    stage_if cf_s ();
    stage_if rl_s ();
    assign raw_s.valid = raw_vld_r;
    assign raw_s.data  = raw_r;

    s_curve_shaper u_shaper (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .accel_ms (accel_r),
        .decel_ms (decel_r),
        .s_const  (scurve_r),
        .in_s     (raw_s),
        .out_s    (shp_s)
    );
    // filter sees every source; bypass at zero
    iir_lowpass u_cmd_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .setting (cmdfilt_r),
        .in_s    (shp_s),
        .out_s   (cf_s)
    );
    iir_lowpass u_res_lp (
        .hclk    (hclk),
        .hresetn (hresetn),
        .setting (reslp_r),
        .in_s    (cf_s),
        .out_s   (rl_s)
    );

    // =================================================================
    // notch as state-variable filter: x minus depth-weighted band-pass
    logic signed [31:0] nlp_r;
    logic signed [31:0] nbp_r;
    wire  signed [31:0] nx   = 32'(rl_s.data) <<< 8;
    wire  signed [31:0] fq   = $signed({16'h0000, nfreq_r * `VC_NOTCH_FQ});
    wire  signed [31:0] nhp  = nx - nlp_r - nbp_r;
    wire  signed [63:0] bp_d = (64'(fq) * 64'(nhp)) >>> 16;
    wire  signed [63:0] lp_d = (64'(fq) * 64'(nbp_r)) >>> 16;
    wire  signed [47:0] cut  = (48'(nbp_r) * $signed({37'h0, ndepth_r, 3'b000})) >>> 16;
    wire  signed [33:0] nout = 34'(rl_s.data) - 34'(cut);
    wire  rpm_t         ny   = clamp(nout, 16'h7FFF);
    // torque mode turns the command into a magnitude limit
    wire  rpm_t         lim  = ny[15] ? -ny : ny;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nlp_r         <= '0;
            nbp_r         <= '0;
            speed_cmd_r   <= 16'h0000;
            speed_limit_r <= 16'h0000;
            cmd_valid_r   <= 1'b0;
        end else begin
            cmd_valid_r <= rl_s.valid;
            if (rl_s.valid) begin
                nbp_r         <= nbp_r + bp_d[31:0];
                nlp_r         <= nlp_r + lp_d[31:0];
                speed_cmd_r   <= mode_torque ? 16'h0000 : ny;
                speed_limit_r <= mode_torque ? lim : 16'h0000;
            end
        end
    end

    // outputs straight from flops; ready held high by a flop
    logic hresetn_q;
    assign hrdata      = hrdata_r;
    assign hreadyout   = 1'b1 & hresetn_q;
    assign hresp       = 1'b0 & hresetn_q;
    assign speed_cmd   = speed_cmd_r;
    assign speed_limit = speed_limit_r;
    assign cmd_valid   = cmd_valid_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hresetn_q <= 1'b1;
        else hresetn_q <= 1'b1;
    end

    // =================================================================
    // assertions
    AST_ZERO_MODE: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && sel_now == 2'b00 && mode_zero |=> raw_r == 16'h0000)
        else $error("zero mode command not zero");
    AST_PRESET_PICK: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && sel_now == 2'b10 |=> raw_r == $past(preset_r[1]) && src_r == SRC_PRESET2)
        else $error("select 10 did not pick preset two");
    AST_PRESET_LIM: assert property (@(posedge hclk) disable iff (!hresetn)
        preset_r[0] <= 16'sd5000 && preset_r[0] >= -16'sd5000)
        else $error("preset one out of range");
    AST_SEL_NOW: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_now != sel_r |=> raw_vld_r && src_r != SRC_ZERO || sel_r == 2'b00)
        else $error("select change not applied at once");
    AST_ANALOG_CLAMP: assert property (@(posedge hclk) disable iff (!hresetn)
        raw_vld_r && src_r == SRC_ANALOG |-> raw_r <= $signed({1'b0, fscale_r[14:0]}))
        else $error("analog command above full scale");
    AST_ANALOG_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && sel_now == 2'b00 && !mode_zero |=> src_r == SRC_ANALOG)
        else $error("analog mode did not take analog source");
    AST_TORQUE_LIM: assert property (@(posedge hclk) disable iff (!hresetn)
        rl_s.valid && mode_torque |=> speed_cmd_r == 16'h0000 && !speed_limit_r[15])
        else $error("torque mode still drives speed command");
    AST_BYPASS: assert property (@(posedge hclk) disable iff (!hresetn)
        shp_s.valid && cmdfilt_r == 8'h00 |=> cf_s.data == $past(shp_s.data))
        else $error("command filter not bypassed at zero");
    AST_NOTCH_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
        nfreq_r >= 16'd50 && nfreq_r <= 16'd1000 && ndepth_r <= 8'd32)
        else $error("notch setting out of range");
    AST_LATENCY: assert property (@(posedge hclk) disable iff (!hresetn)
        raw_vld_r |-> ##[3:4] cmd_valid_r)
        else $error("filtered command late in sample");
    COV_ANALOG: cover property (@(posedge hclk) raw_vld_r && src_r == SRC_ANALOG);
    COV_PRESET3: cover property (@(posedge hclk) raw_vld_r && src_r == SRC_PRESET3);
    COV_TORQUE: cover property (@(posedge hclk) cmd_valid_r && speed_limit_r != 16'h0000);
endmodule

// file: verification/motion_ctl_model.sv
// far-side controller model: drives the select lines and the analog reference
`timescale 1ns/1ps
module motion_ctl_model (
    // clock
    input  wire logic               hclk,
    // requested levels from the bench
    input  wire logic [1:0]         want_sel,
    input  wire logic signed [15:0] want_mv,
    // controller pins
    output logic                    speed_select_bit0,
    output logic                    speed_select_bit1,
    output logic signed [15:0]      analog_ref_mv
);
    // =====================================================================
    // pins change just after an edge, like a real digital output card
    // reference kept inside +-10 V
    always @(posedge hclk) begin
        speed_select_bit0 <= want_sel[0];
        speed_select_bit1 <= want_sel[1];
        analog_ref_mv     <= (want_mv > 10000) ? 16'sd10000 :
                             (want_mv < -10000) ? -16'sd10000 : want_mv;
    end
endmodule

// file: verification/test_velocity_command_select.sv
// self-checking bench for the velocity command selector
`timescale 1ns/1ps
`include "vcmd_cfg.svh"
module test_velocity_command_select;
    import vcmd_pkg::*;
    // =====================================================================
    // signals
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0]  htrans = 2'b00, want_sel = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, cmd_valid, s0, s1;
    logic signed [15:0] want_mv = '0, amv;
    rpm_t        speed_cmd, speed_limit;
    int          n_fail = 0, total_checks = 0, cyc = 0, fs = 3000, off, p[4], e;
    always #10 hclk = ~hclk;
    // =====================================================================
    // design and controller
    velocity_command_select #(.SAMPLE_CYCLES(32)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .speed_select_bit0(s0), .speed_select_bit1(s1),
        .analog_ref_mv(amv), .speed_cmd(speed_cmd), .speed_limit(speed_limit),
        .cmd_valid(cmd_valid));
    motion_ctl_model ctl (.hclk(hclk), .want_sel(want_sel), .want_mv(want_mv),
        .speed_select_bit0(s0), .speed_select_bit1(s1), .analog_ref_mv(amv));
    // =====================================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // single ahb-lite transfer; waits on hready, never on a cycle count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= 2'b10; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask
    // a result counts only when it is delivered with cmd_valid inside the bound
    task automatic want(input string nm, input int ec, input int el, input int bound);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < bound && !hit; i++) begin
            @(posedge hclk);
            #1;
            hit = (cmd_valid === 1'b1) && (speed_cmd === 16'(ec)) && (speed_limit === 16'(el));
        end
        chk(nm, 32'h0000_0001, {31'h0000_0000, hit});
    endtask
    function automatic int ana(input int mv);
        int v;
        v = fs * (mv - off) / 10000;
        return (v > fs) ? fs : (v < -fs) ? -fs : v;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // =====================================================================
    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    // =====================================================================
    // main sequence
    initial begin
        void'($urandom(9));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `VC_OFF_FSCALE, 0); chk("fscale_rst", 32'h0000_0BB8, q);
        bus(0, `VC_OFF_ACCEL, 0);  chk("accel_rst", 32'h0000_00C8, q);
        bus(0, `VC_OFF_NFREQ, 0);  chk("nfreq_rst", 32'h0000_03E8, q);
        bus(0, 8'h80, 0);          chk("unmapped", 32'h0000_0000, q);
        bus(1, `VC_OFF_ACCEL, 0);
        bus(1, `VC_OFF_DECEL, 0);
        bus(1, `VC_OFF_NFREQ, 2000);
        bus(0, `VC_OFF_NFREQ, 0);  chk("nfreq_clamp", 32'h0000_03E8, q);
        bus(1, `VC_OFF_PRESET1, 6000);
        bus(0, `VC_OFF_PRESET1, 0); chk("preset_clamp", 32'h0000_1388, q);
        // presets on select codes 01, 10 and 11, back to back changes
        for (int k = 1; k < 4; k++) begin
            p[k] = int'($urandom % 10001) - 5000;
            bus(1, 8'(4 * k), p[k]);
        end
        for (int k = 1; k < 4; k++) begin
            want_sel <= 2'(k);
            want($sformatf("preset%0d", k), p[k], 0, 8);
        end
        // analog path, including the clamp
        want_sel <= 2'b00;
        off = 0;
        for (int k = 0; k < 4; k++) begin
            e = (int'($urandom % 2001) - 1000) * 10;
            want_mv <= 16'(e);
            want("analog", ana(e), 0, 80);
        end
        off = -5000;
        bus(1, `VC_OFF_OFFSET, 32'hFFFF_EC78);
        want_mv <= 16'sd8000;
        want("analog_clamp", ana(8000), 0, 80);
        // zero mode ignores the analog input
        bus(1, `VC_OFF_CTRL, 32'h0000_0001);
        want("zero_mode", 0, 0, 80);
        // torque mode: preset becomes a limit
        want_sel <= 2'b10;
        bus(1, `VC_OFF_CTRL, 32'h0000_0003);
        want("torque", 0, (p[2] < 0) ? -p[2] : p[2], 80);
        bus(0, `VC_OFF_STATUS, 0); chk("status", 32'h0000_000E, q);
        bus(0, `VC_OFF_CMDOUT, 0);
        chk("cmdout", {16'((p[2] < 0) ? -p[2] : p[2]), 16'h0000}, q);
        bus(1, `VC_OFF_NFREQ, 32'h0000_012C);
        bus(1, `VC_OFF_NDEPTH, 32'h0000_0040);
        bus(0, `VC_OFF_NDEPTH, 0); chk("ndepth_clamp", 32'h0000_0020, q);
        bus(0, `VC_OFF_NFREQ, 0);  chk("nfreq_set", 32'h0000_012C, q);
        conclude();
    end
endmodule
